/* fal_loader.sv */
`timescale 1ns/1ps
// Summary of operation
// - fuse load checking is always on from reset, no software control
// - any load failure is recorded in the readable error status register
// - load failure or uncorrectable error asserts reset and retries the load
// - secded code checks every fuse word, corrects single errors, reports errors
// - error correction is enabled from reset and cannot be disabled
// - correction covers both the data bits and the check bits of each fuse word
// - correction logic self-test runs automatically after reset and before each load retry
// - self-test failure reported in error status and system control outputs
// - device reset held while the self-test keeps failing
module fal_loader (
   input wire logic clk,
   input wire logic sys_rst,
   output logic [fal_pkg::ADDR_W-1:0] fuse_addr,
   output logic fuse_rd,
   input wire logic [fal_pkg::WORD_W-1:0] fuse_rdata,
   input wire logic fuse_rvalid,
   output logic cfg_we,
   output logic [fal_pkg::ADDR_W-1:0] cfg_addr,
   output logic [fal_pkg::DATA_W-1:0] cfg_wdata,
   output logic [fal_pkg::ST_W-1:0] fuse_error_status_reg,
   output logic sysctl_bist_fail,
   output logic dev_rst
);

   // ----------------------------------------------------------------
   // secded helpers: hamming(21,16) plus overall parity
   // ----------------------------------------------------------------
   // codeword positions 1..21 carry hamming bits, check bits at powers of two
   function automatic logic [fal_pkg::WORD_W-1:0] enc(input logic [fal_pkg::DATA_W-1:0] d);
      logic [21:1] cw;
      logic [fal_pkg::WORD_W-1:0] w;
      int k;
      cw = '0;
      k = 0;
      for (int p = 1; p <= 21; p++) begin
         if ((p & (p - 1)) != 0) begin
            cw[p] = d[k];
            k++;
         end
      end
      for (int b = 0; b < 5; b++) begin
         for (int p = 1; p <= 21; p++) begin
            if (((p >> b) & 1) == 1 && p != (1 << b)) begin
               cw[1 << b] = cw[1 << b] ^ cw[p];
            end
         end
      end
      w = {^cw, cw};
      return w;
   endfunction

   // result: {uncorr, corr, data}
   function automatic logic [fal_pkg::DATA_W+1:0] dec(input logic [fal_pkg::WORD_W-1:0] w);
      logic [21:1] cw;
      logic [4:0] syn;
      logic par;
      logic [fal_pkg::DATA_W-1:0] d;
      logic c;
      logic u;
      int k;
      cw = w[20:0];
      par = ^w;
      syn = '0;
      for (int p = 1; p <= 21; p++) begin
         if (cw[p]) begin
            syn = syn ^ 5'(p);
         end
      end
      c = 1'b0;
      u = 1'b0;
      if (syn != 5'h00 && !par) begin
         u = 1'b1;
      end else if (par) begin
         c = 1'b1;
         if (syn != 5'h00 && syn <= 5'h15) begin
            cw[syn] = ~cw[syn];
         end else if (syn > 5'h15) begin
            u = 1'b1;
            c = 1'b0;
         end
      end
      d = '0;
      k = 0;
      for (int p = 1; p <= 21; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[k] = cw[p];
            k++;
         end
      end
      return {u, c, d};
   endfunction

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   fal_pkg::fal_state_t state_r, state_nxt;
   logic [fal_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic [fal_pkg::ST_W-1:0] st_r, st_nxt;
   logic bist_fail_r, bist_fail_nxt;
   logic rst_r, rst_nxt;
   logic rd_r, rd_nxt;
   logic we_r, we_nxt;
   logic [fal_pkg::DATA_W-1:0] wd_r, wd_nxt;
   logic [fal_pkg::ADDR_W-1:0] wa_r, wa_nxt;
   logic [fal_pkg::DATA_W+1:0] rom_dec;
   logic [fal_pkg::DATA_W+1:0] t0, t1, t2;
   logic bist_ok;

   // self-test: clean, one flipped, two flipped codewords through the decoder
   assign t0 = dec(enc(fal_pkg::BIST_PAT));
   assign t1 = dec(enc(fal_pkg::BIST_PAT) ^ fal_pkg::BIST_FLIP1);
   assign t2 = dec(enc(fal_pkg::BIST_PAT) ^ fal_pkg::BIST_FLIP2);
   assign bist_ok = (t0 == {2'b00, fal_pkg::BIST_PAT})
      && (t1 == {2'b01, fal_pkg::BIST_PAT})
      && t2[fal_pkg::DATA_W+1];
   // the whole 22-bit word is decoded; check bits never reach the registers
   assign rom_dec = dec(fuse_rdata);

   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      st_nxt = st_r;
      bist_fail_nxt = bist_fail_r;
      rst_nxt = rst_r;
      rd_nxt = 1'b0;
      we_nxt = 1'b0;
      wd_nxt = wd_r;
      wa_nxt = wa_r;
      unique case (state_r)
         fal_pkg::FAL_BIST: begin
            rst_nxt = 1'b1;
            if (bist_ok) begin
               bist_fail_nxt = 1'b0;
               state_nxt = fal_pkg::FAL_ADDR;
            end else begin
               // stays here, device kept in reset while it keeps failing
               bist_fail_nxt = 1'b1;
               st_nxt[fal_pkg::ST_BIST_ERR] = 1'b1;
            end
         end
         fal_pkg::FAL_ADDR: begin
            rd_nxt = 1'b1;
            state_nxt = fal_pkg::FAL_WAIT;
         end
         fal_pkg::FAL_WAIT: begin
            if (fuse_rvalid) begin
               state_nxt = fal_pkg::FAL_CHECK;
            end
         end
         fal_pkg::FAL_CHECK: begin
            if (rom_dec[fal_pkg::DATA_W+1]) begin
               st_nxt[fal_pkg::ST_UNCORR] = 1'b1;
               st_nxt[fal_pkg::ST_LOAD_ERR] = 1'b1;
               state_nxt = fal_pkg::FAL_RETRY;
            end else begin
               if (rom_dec[fal_pkg::DATA_W]) begin
                  st_nxt[fal_pkg::ST_CORR] = 1'b1;
               end
               we_nxt = 1'b1;
               wa_nxt = addr_r;
               wd_nxt = rom_dec[fal_pkg::DATA_W-1:0];
               if (addr_r == fal_pkg::LAST_ADDR) begin
                  state_nxt = fal_pkg::FAL_DONE;
               end else begin
                  addr_nxt = addr_r + 3'h1;
                  state_nxt = fal_pkg::FAL_ADDR;
               end
            end
         end
         fal_pkg::FAL_DONE: begin
            rst_nxt = 1'b0;
         end
         fal_pkg::FAL_RETRY: begin
            // reset stays asserted; self-test runs again before the next read
            rst_nxt = 1'b1;
            addr_nxt = '0;
            state_nxt = fal_pkg::FAL_BIST;
         end
         // unused state codes fall back to a fresh self-test, reset held
         default: begin
            rst_nxt = 1'b1;
            state_nxt = fal_pkg::FAL_BIST;
         end
      endcase
   end

   // check is unconditional from reset; no software path exists to alter it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= fal_pkg::FAL_BIST;
         addr_r <= '0;
         st_r <= fal_pkg::ST_RESET;
         bist_fail_r <= 1'b0;
         rst_r <= 1'b1;
         rd_r <= 1'b0;
         we_r <= 1'b0;
         wd_r <= '0;
         wa_r <= '0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         st_r <= st_nxt;
         bist_fail_r <= bist_fail_nxt;
         rst_r <= rst_nxt;
         rd_r <= rd_nxt;
         we_r <= we_nxt;
         wd_r <= wd_nxt;
         wa_r <= wa_nxt;
      end
   end

   assign fuse_addr = addr_r;
   assign fuse_rd = rd_r;
   assign cfg_we = we_r;
   assign cfg_addr = wa_r;
   assign cfg_wdata = wd_r;
   assign fuse_error_status_reg = st_r;
   assign sysctl_bist_fail = bist_fail_r;
   assign dev_rst = rst_r;

endmodule // fal_loader

/* fal_loader_assertions.sv */
`timescale 1ns/1ps
module fal_loader_assertions (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] fuse_addr,
   input wire logic fuse_rd,
   input wire logic fuse_rvalid,
   input wire logic cfg_we,
   input wire logic [2:0] cfg_addr,
   input wire logic [3:0] fuse_error_status_reg,
   input wire logic sysctl_bist_fail,
   input wire logic dev_rst
);
   // ------------------------------
   // load sequencing
   // ------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd0;
      fuse_rd && fuse_addr == 3'h0;
   endsequence
   sequence s_last_wr;
      $past(cfg_we) && $past(cfg_addr) == 3'h7;
   endsequence
   a_rst_held: assert property (sysctl_bist_fail |-> dev_rst)
      else $error("self-test failing without reset");
   a_bist_status: assert property (sysctl_bist_fail |-> fuse_error_status_reg[3])
      else $error("self-test fail not in status");
   a_status_sticky: assert property (($past(fuse_error_status_reg) & ~fuse_error_status_reg) == 4'h0)
      else $error("status bit lost");
   a_we_timing: assert property (cfg_we |-> $past(fuse_rvalid, 2))
      else $error("config write not two cycles after read data");
   a_first_read: assert property ($fell(sys_rst) |-> ##[1:3] s_rd0)
      else $error("no read of word 0 after reset");
   a_uncorr_retry: assert property ($rose(fuse_error_status_reg[2]) |-> (dev_rst && fuse_error_status_reg[0]) ##[1:12] s_rd0)
      else $error("no retry after uncorrectable word");
   a_release_last: assert property ($fell(dev_rst) |-> s_last_wr)
      else $error("reset released before last word");
   a_quiet_after: assert property (!dev_rst |-> !cfg_we && !fuse_rd)
      else $error("load activity after release");
endmodule // fal_loader_assertions
bind fal_loader fal_loader_assertions fal_loader_assertions_i (.clk, .sys_rst, .fuse_addr,
   .fuse_rd, .fuse_rvalid, .cfg_we, .cfg_addr, .fuse_error_status_reg, .sysctl_bist_fail,
   .dev_rst);

/* fal_pkg.sv */
package fal_pkg;
   // fuse word layout: 16 data bits protected by a 6-bit secded code
   localparam int DATA_W = 16;
   localparam int CHK_W = 6;
   localparam int WORD_W = DATA_W + CHK_W;
   localparam int NWORDS = 8;
   localparam int ADDR_W = 3;
   localparam logic [ADDR_W-1:0] LAST_ADDR = 3'h7;
   // fuse rom read latency in cycles (read data valid next cycle)
   localparam int ROM_LAT = 1;
   // error status bit positions
   localparam int ST_LOAD_ERR = 0;
   localparam int ST_CORR = 1;
   localparam int ST_UNCORR = 2;
   localparam int ST_BIST_ERR = 3;
   localparam int ST_W = 4;
   localparam logic [ST_W-1:0] ST_RESET = 4'h0;
   // self-test pattern, injected single and double faults
   localparam logic [DATA_W-1:0] BIST_PAT = 16'hA5C3;
   localparam logic [WORD_W-1:0] BIST_FLIP1 = 22'h000010;
   localparam logic [WORD_W-1:0] BIST_FLIP2 = 22'h000101;
   typedef enum logic [2:0] {
      FAL_BIST, FAL_ADDR, FAL_WAIT, FAL_CHECK, FAL_DONE, FAL_RETRY
   } fal_state_t;
endpackage

/* fal_rom_model.sv */
`timescale 1ns/1ps
module fal_rom_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic fuse_rd,
   input wire logic [2:0] fuse_addr,
   output logic [21:0] fuse_rdata,
   output logic fuse_rvalid
);
   logic [21:0] mem [8];
   logic [2:0] a_r = 3'h0;
   int cnt = 0;
   initial fuse_rdata = 22'h0;
   initial fuse_rvalid = 1'b0;
   // data holds one cycle past the valid pulse, then scrambles
   always @(posedge clk) begin
      fuse_rvalid <= 1'b0;
      if (cnt > 0) cnt <= cnt - 1;
      if ((fuse_rd && !slow) || cnt == 1) begin
         fuse_rvalid <= 1'b1;
         fuse_rdata <= mem[fuse_rd ? fuse_addr : a_r];
      end else if (!fuse_rvalid) fuse_rdata <= ~fuse_rdata;
      if (fuse_rd) begin
         a_r <= fuse_addr;
         cnt <= slow ? 2 : 0;
      end
   end
endmodule // fal_rom_model

/* tb_fal_loader.sv */
`timescale 1ns/1ps
module tb_fal_loader;
   logic clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, fuse_rd, fuse_rvalid, cfg_we;
   logic sysctl_bist_fail, dev_rst;
   logic [2:0] fuse_addr, cfg_addr;
   logic [21:0] fuse_rdata;
   logic [15:0] cfg_wdata, r = 16'h0058;
   logic [15:0] exp_d [8];
   logic [3:0] st;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   // writes seen since reset; skip is the write count of an aborted first pass
   int n_wr = 0, skip = 8;
   always #20 clk = ~clk;
   fal_loader fal_loader_i (.clk, .sys_rst, .fuse_addr, .fuse_rd, .fuse_rdata, .fuse_rvalid,
      .cfg_we, .cfg_addr, .cfg_wdata, .fuse_error_status_reg(st), .sysctl_bist_fail, .dev_rst);
   fal_rom_model rom (.clk, .slow, .fuse_rd, .fuse_addr, .fuse_rdata, .fuse_rvalid);
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [21:0] enc(input logic [15:0] d);
      logic [21:0] w;
      int k;
      w = 22'h0;
      k = 0;
      for (int p = 1; p < 22; p++) begin
         if ((p & (p - 1)) != 0) begin
            w[p-1] = d[k];
            k++;
         end
      end
      for (int p = 1; p < 22; p++) begin
         for (int c = 1; c < 32; c *= 2) begin
            if ((p & c) != 0 && p != c) w[c-1] ^= w[p-1];
         end
      end
      w[21] = ^w[20:0];
      return w;
   endfunction
   task automatic chk(input logic [21:0] seen, input logic [21:0] want, input string what);
      cmp_count++;
      if (seen !== want) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask
   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------
   // monitor and watchdog
   // ------------------------------
   always @(negedge clk) begin
      cyc++;
      if (sys_rst) n_wr = 0;
      else if (cfg_we) begin
         chk(22'(cfg_wdata), 22'(exp_d[cfg_addr]), "cfg_wdata");
         chk(22'(cfg_addr), 22'(n_wr >= skip ? n_wr - skip : n_wr), "cfg_addr");
         n_wr++;
      end
      if (cyc == 20000) begin
         n_fail++;
         conclude;
      end
   end
   // mode 0 clean, 1 slow rom, 2 one flipped bit, 3 two flipped bits
   task run(input int mode, input bit par);
      int p, q, a;
      @(posedge clk);
      sys_rst <= 1'b1;
      slow <= (mode == 1);
      for (int i = 0; i < 8; i++) begin
         r = nx(r);
         exp_d[i] = r;
         rom.mem[i] = enc(r);
      end
      r = nx(r);
      a = r[10:8];
      skip = (mode == 3) ? a : 8;
      p = par ? 21 : r % 22;
      q = (p + 1 + r[7:4] % 21) % 22;
      if (mode >= 2) rom.mem[a][p] ^= 1'b1;
      if (mode == 3) rom.mem[a][q] ^= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 600 && dev_rst !== 1'b0; i++) begin
         @(negedge clk);
         if (st[2] === 1'b1) rom.mem[a] = enc(exp_d[a]);
      end
      chk(22'(dev_rst), 22'h0, "dev_rst");
      chk(22'(st), mode == 2 ? 22'h2 : mode == 3 ? 22'h5 : 22'h0, "status");
      chk(22'(sysctl_bist_fail), 22'h0, "bist_fail");
      chk(22'(n_wr), 22'(mode == 3 ? a + 8 : 8), "word count");
   endtask
   initial begin
      for (int k = 0; k < 12; k++) run(k % 4, k == 2);
      conclude;
   end
endmodule // tb_fal_loader
